// ### rkpb_top.sv
`timescale 1ns/1ps
module rkpb_top
(
   // Clock and reset
   input  wire logic              clk_i,
   input  wire logic              reset_i,
   // AXI4-Lite write address
   input  wire logic              s_axi_awvalid,
   output logic                   s_axi_awready,
   input  wire logic [11:0]       s_axi_awaddr,
   // AXI4-Lite write data
   input  wire logic              s_axi_wvalid,
   output logic                   s_axi_wready,
   input  wire rkpb_pkg::rkpb_word_t s_axi_wdata,
   input  wire logic [3:0]        s_axi_wstrb,
   // AXI4-Lite write response
   output logic                   s_axi_bvalid,
   input  wire logic              s_axi_bready,
   output logic [1:0]             s_axi_bresp,
   // AXI4-Lite read address
   input  wire logic              s_axi_arvalid,
   output logic                   s_axi_arready,
   input  wire logic [11:0]       s_axi_araddr,
   // AXI4-Lite read data
   output logic                   s_axi_rvalid,
   input  wire logic              s_axi_rready,
   output rkpb_pkg::rkpb_word_t   s_axi_rdata,
   output logic [1:0]             s_axi_rresp,
   // Partition outputs
   output logic [15:0]            kernel_program_ram_base_o,
   output logic                   kernel_program_active_o
);
   import rkpb_pkg::*;

   // ----------------------------------------------------------------
   // Write channel capture
   // ----------------------------------------------------------------
   logic        aw_held_reg;
   logic [11:0] aw_addr_reg;
   logic        w_held_reg;
   logic [31:0] w_data_reg;
   logic [3:0]  w_strb_reg;
   logic        bvalid_reg;
   logic [1:0]  bresp_reg;
   logic        awready_reg;
   logic        wready_reg;
   logic        arready_reg;

   // Address and data are taken in either order and held until both
   // are present; the response then stands until bready.
   wire aw_take  = s_axi_awvalid && awready_reg;
   wire w_take   = s_axi_wvalid && wready_reg;
   wire wr_fire  = aw_held_reg && w_held_reg && !bvalid_reg;
   wire wr_kpb   = wr_fire && (aw_addr_reg[11:2] == RKPB_KPB_OFFSET[11:2]);
   wire wr_size  = wr_fire && (aw_addr_reg[11:2] == RKPB_SIZE_OFFSET[11:2]);
   wire wr_stat  = wr_fire && (aw_addr_reg[11:2] == RKPB_STAT_OFFSET[11:2]);
   wire wr_known = wr_kpb || wr_size || wr_stat;

   // Base: only lane 1 holds writable bits, lanes 0, 2 and 3 are dropped; size loads only when lanes 0, 1 and 2 are all set.
   wire kpb_load  = wr_kpb && w_strb_reg[1];
   wire size_load = wr_size && (&w_strb_reg[2:0]);

   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         aw_held_reg <= 1'b0;
         aw_addr_reg <= 12'h000;
         w_held_reg  <= 1'b0;
         w_data_reg  <= 32'h00000000;
         w_strb_reg  <= 4'h0;
         bvalid_reg  <= 1'b0;
         bresp_reg   <= RKPB_RESP_OKAY;
      end else begin
         if (aw_take) begin
            aw_held_reg <= 1'b1;
            aw_addr_reg <= s_axi_awaddr;
         end
         if (w_take) begin
            w_held_reg <= 1'b1;
            w_data_reg <= s_axi_wdata;
            w_strb_reg <= s_axi_wstrb;
         end
         if (wr_fire) begin
            aw_held_reg <= 1'b0;
            w_held_reg  <= 1'b0;
            bvalid_reg  <= 1'b1;
            // Low read-only bits take writes silently: still OKAY
            bresp_reg   <= wr_known ? RKPB_RESP_OKAY
                                    : RKPB_RESP_SLVERR;
         end else if (bvalid_reg && s_axi_bready) begin
            bvalid_reg <= 1'b0;
         end
      end
   end

   // ----------------------------------------------------------------
   // Registers
   // ----------------------------------------------------------------
   logic [RKPB_BASE_W-1:0] base_field;
   logic [RKPB_SIZE_W-1:0] size_reg;

   rkpb_field #(
      .WIDTH (RKPB_BASE_W),
      .RESET (RKPB_BASE_RESET)
   ) u_base (
      .clk_i   (clk_i),
      .reset_i (reset_i),
      .load_i  (kpb_load),
      .data_i  (w_data_reg[RKPB_BASE_MSB:RKPB_BASE_LSB]),
      .value_o (base_field)
   );

   // Companion size value the base is checked against
   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         size_reg <= RKPB_SIZE_RESET;
      end else if (size_load) begin
         size_reg <= w_data_reg[RKPB_SIZE_W-1:0];
      end
   end

   // Base with hard-wired zero low bits and unimplemented upper half
   wire [31:0] kpb_word = {16'h0000, base_field, 10'h000};
   wire [16:0] kpb_ext  = {1'b0, kpb_word[15:0]};
   // Flags a base above the size value; software must avoid this
   wire        over     = kpb_ext > size_reg;
   wire        active   = |base_field;
   wire [31:0] stat_word = {30'h00000000, active, over};

   // ----------------------------------------------------------------
   // Read channel
   // ----------------------------------------------------------------
   logic        rvalid_reg;
   logic [31:0] rdata_reg;
   logic [1:0]  rresp_reg;

   wire ar_take  = s_axi_arvalid && arready_reg;
   wire rd_kpb   = s_axi_araddr[11:2] == RKPB_KPB_OFFSET[11:2];
   wire rd_size  = s_axi_araddr[11:2] == RKPB_SIZE_OFFSET[11:2];
   wire rd_stat  = s_axi_araddr[11:2] == RKPB_STAT_OFFSET[11:2];
   // Unmapped offsets read zero and answer SLVERR
   wire [31:0] rd_mux = rd_kpb  ? kpb_word
                      : rd_size ? {15'h0000, size_reg}
                      : rd_stat ? stat_word
                      : 32'h00000000;
   wire rd_known = rd_kpb || rd_size || rd_stat;

   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         rvalid_reg <= 1'b0;
         rdata_reg  <= 32'h00000000;
         rresp_reg  <= RKPB_RESP_OKAY;
      end else if (ar_take) begin
         rvalid_reg <= 1'b1;
         rdata_reg  <= rd_mux;
         rresp_reg  <= rd_known ? RKPB_RESP_OKAY : RKPB_RESP_SLVERR;
      end else if (rvalid_reg && s_axi_rready) begin
         rvalid_reg <= 1'b0;
      end
   end

   // ----------------------------------------------------------------
   // Outputs
   // ----------------------------------------------------------------
   // The partition outputs trail the register by one cycle; a write
   // reaches them one clock after its response is raised.
   logic [15:0] base_out_reg;
   logic        active_out_reg;

   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         base_out_reg   <= 16'h0000;
         active_out_reg <= 1'b0;
      end else begin
         base_out_reg   <= kpb_word[15:0];
         active_out_reg <= active;
      end
   end

   // ----------------------------------------------------------------
   // Ready flags
   // ----------------------------------------------------------------
   // Each ready is the registered "free next cycle" term, so a beat is
   // only taken while its ready is really shown on the port.
   wire b_busy_next  = wr_fire || (bvalid_reg && !s_axi_bready);
   wire aw_busy_next = (aw_held_reg || aw_take) && !wr_fire;
   wire w_busy_next  = (w_held_reg || w_take) && !wr_fire;
   wire r_busy_next  = ar_take || (rvalid_reg && !s_axi_rready);

   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         awready_reg <= 1'b0;
         wready_reg  <= 1'b0;
         arready_reg <= 1'b0;
      end else begin
         awready_reg <= !aw_busy_next && !b_busy_next;
         wready_reg  <= !w_busy_next && !b_busy_next;
         arready_reg <= !r_busy_next;
      end
   end

   assign s_axi_awready = awready_reg;
   assign s_axi_wready  = wready_reg;
   assign s_axi_arready = arready_reg;
   assign s_axi_bvalid  = bvalid_reg;
   assign s_axi_bresp   = bresp_reg;
   assign s_axi_rvalid  = rvalid_reg;
   assign s_axi_rdata   = rdata_reg;
   assign s_axi_rresp   = rresp_reg;
   assign kernel_program_ram_base_o = base_out_reg;
   assign kernel_program_active_o   = active_out_reg;
endmodule

// ### rkpb_pkg.sv
package rkpb_pkg;

   // -----------------------------------------------------------------
   // Register map
   // -----------------------------------------------------------------
   localparam logic [11:0] RKPB_KPB_OFFSET  = 12'h000;
   localparam logic [11:0] RKPB_SIZE_OFFSET = 12'h004;
   localparam logic [11:0] RKPB_STAT_OFFSET = 12'h008;

   // -----------------------------------------------------------------
   // Field layout
   // -----------------------------------------------------------------
   localparam int          RKPB_BASE_LSB    = 10;
   localparam int          RKPB_BASE_MSB    = 15;
   localparam int          RKPB_BASE_W      = 6;
   localparam int          RKPB_SIZE_W      = 17;
   localparam int          RKPB_STAT_OVER   = 0;
   localparam int          RKPB_STAT_ACTIVE = 1;

   // -----------------------------------------------------------------
   // Reset values and bus answers
   // -----------------------------------------------------------------
   localparam logic [5:0]  RKPB_BASE_RESET  = 6'h00;
   localparam logic [16:0] RKPB_SIZE_RESET  = 17'h00000;
   localparam logic [1:0]  RKPB_RESP_OKAY   = 2'h0;
   localparam logic [1:0]  RKPB_RESP_SLVERR = 2'h2;

   typedef logic [31:0] rkpb_word_t;

endpackage

// ### rkpb_field.sv
`timescale 1ns/1ps
// Holds one writable field; byte lanes covering any bit of it load it.
module rkpb_field
   import rkpb_pkg::*;
#(
   parameter int         WIDTH = 6,
   parameter logic [5:0] RESET = 6'h00
) (
   // Clock and reset
   input  wire logic             clk_i,
   input  wire logic             reset_i,
   // Load
   input  wire logic             load_i,
   input  wire logic [WIDTH-1:0] data_i,
   // Stored value
   output logic      [WIDTH-1:0] value_o
);
   logic [WIDTH-1:0] value_reg;

   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         value_reg <= RESET[WIDTH-1:0];
      end else if (load_i) begin
         value_reg <= data_i;
      end
   end

   assign value_o = value_reg;
endmodule

// ### rkpb_monitor.sv
`timescale 1ns/1ps
module rkpb_monitor
   import rkpb_pkg::*;
(
   // Clock and reset
   input wire logic                 clk_i,
   input wire logic                 reset_i,
   // Bus
   input wire logic                 s_axi_awvalid,
   input wire logic                 s_axi_awready,
   input wire logic [11:0]          s_axi_awaddr,
   input wire logic                 s_axi_bvalid,
   input wire logic [1:0]           s_axi_bresp,
   input wire logic                 s_axi_arvalid,
   input wire logic                 s_axi_arready,
   input wire logic [11:0]          s_axi_araddr,
   input wire logic                 s_axi_rvalid,
   input wire rkpb_pkg::rkpb_word_t s_axi_rdata,
   // Partition
   input wire logic [15:0]          kernel_program_ram_base_o
);
   default clocking @(posedge clk_i); endclocking
   default disable iff (reset_i);
   // Addresses of the transfer in flight; the bus drops them early
   logic [11:0] ra_reg;
   logic [11:0] wa_reg;
   always_ff @(posedge clk_i) begin
      if (s_axi_arvalid && s_axi_arready)
         ra_reg <= s_axi_araddr;
      if (s_axi_awvalid && s_axi_awready)
         wa_reg <= s_axi_awaddr;
   end
   AST_HIGH_ZERO: assert property (
      s_axi_rvalid && ra_reg == RKPB_KPB_OFFSET |-> s_axi_rdata[31:16] == 16'h0)
      else $error("Base upper bits read nonzero");
   AST_LOW_ZERO: assert property (
      s_axi_rvalid && ra_reg == RKPB_KPB_OFFSET |-> s_axi_rdata[9:0] == 10'h0)
      else $error("Base low bits read nonzero");
   AST_OUT_LOW: assert property (
      kernel_program_ram_base_o[9:0] == 10'h0) else $error("Base out low bits");
   AST_RD_MATCH: assert property (
      s_axi_rvalid && ra_reg == RKPB_KPB_OFFSET
      |-> s_axi_rdata[15:0] == kernel_program_ram_base_o)
      else $error("Base read differs from output");
   AST_RST_CLEAR: assert property (
      $fell(reset_i) |-> (kernel_program_ram_base_o == 16'h0) [*2])
      else $error("Base not cleared by reset");
   AST_WR_OKAY: assert property (
      s_axi_bvalid && wa_reg == RKPB_KPB_OFFSET |-> s_axi_bresp == RKPB_RESP_OKAY)
      else $error("Base write answered with error");
endmodule
bind rkpb_top rkpb_monitor u_mon (.clk_i, .reset_i, .s_axi_awvalid,
   .s_axi_awready, .s_axi_awaddr, .s_axi_bvalid, .s_axi_bresp, .s_axi_arvalid,
   .s_axi_arready, .s_axi_araddr, .s_axi_rvalid, .s_axi_rdata,
   .kernel_program_ram_base_o);

// ### tb_ram_kernel_program_base.sv
`timescale 1ns/1ps
module tb_ram_kernel_program_base;
   import rkpb_pkg::*;
   logic        clk_i, reset_i, s_axi_awvalid, s_axi_wvalid, s_axi_bready;
   logic        s_axi_arvalid, s_axi_rready, s_axi_awready, s_axi_wready;
   logic        s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic        kernel_program_active_o;
   logic [11:0] s_axi_awaddr, s_axi_araddr;
   logic [3:0]  s_axi_wstrb, s;
   logic [1:0]  s_axi_bresp, s_axi_rresp;
   logic [5:0]  f;
   logic [15:0] kernel_program_ram_base_o;
   rkpb_word_t  s_axi_wdata, s_axi_rdata, d;
   logic [33:0] q[$];
   int          err_count, n_checks;
   rkpb_top u_dut (.clk_i, .reset_i, .s_axi_awvalid, .s_axi_awready,
      .s_axi_awaddr, .s_axi_wvalid, .s_axi_wready, .s_axi_wdata, .s_axi_wstrb,
      .s_axi_bvalid, .s_axi_bready, .s_axi_bresp, .s_axi_arvalid,
      .s_axi_arready, .s_axi_araddr, .s_axi_rvalid, .s_axi_rready,
      .s_axi_rdata, .s_axi_rresp, .kernel_program_ram_base_o,
      .kernel_program_active_o);
   initial begin
      clk_i = 1'b0;
      forever #4 clk_i = ~clk_i;
   end
   task automatic chk(input logic [33:0] got, input logic [33:0] exp);
      n_checks++;
      if (got !== exp) begin
         err_count++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic summarize();
      if (err_count == 0 && n_checks > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask
   task automatic wr(input logic [11:0] a, input rkpb_word_t v,
                     input logic [3:0] m, input logic [1:0] r);
      @(posedge clk_i);
      q.push_back({r, 32'h0});
      s_axi_awaddr <= a;
      s_axi_wdata <= v;
      s_axi_wstrb <= m;
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
      do begin
         @(posedge clk_i);
         if (s_axi_awready)
            s_axi_awvalid <= 1'b0;
         if (s_axi_wready)
            s_axi_wvalid <= 1'b0;
      end while (!s_axi_bvalid);
      s_axi_bready <= 1'b0;
   endtask
   task automatic rd(input logic [11:0] a, input rkpb_word_t e,
                     input logic [1:0] r);
      @(posedge clk_i);
      q.push_back({r, e});
      s_axi_araddr <= a;
      {s_axi_arvalid, s_axi_rready} <= 2'h3;
      do begin
         @(posedge clk_i);
         if (s_axi_arready)
            s_axi_arvalid <= 1'b0;
      end while (!s_axi_rvalid);
      s_axi_rready <= 1'b0;
   endtask
   // Results are compared in the order the requests were queued
   always @(posedge clk_i) begin
      if (s_axi_rvalid && s_axi_rready)
         chk({s_axi_rresp, s_axi_rdata}, q.pop_front());
      if (s_axi_bvalid && s_axi_bready)
         chk({s_axi_bresp, 32'h0}, q.pop_front());
   end
   initial begin
      repeat (3000) @(posedge clk_i);
      err_count++;
      summarize();
   end
   initial begin
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready,
       s_axi_awaddr, s_axi_araddr, s_axi_wstrb, s_axi_wdata} = '0;
      reset_i = 1'b1;
      void'($urandom(32'h5d49b4b1));
      repeat (16) @(posedge clk_i);
      reset_i <= 1'b0;
      rd(RKPB_KPB_OFFSET, 32'h0, RKPB_RESP_OKAY);
      f = 6'h00;
      // Size at its top so every base stays legal
      wr(RKPB_SIZE_OFFSET, 32'hffffffff, 4'hf, RKPB_RESP_OKAY);
      rd(RKPB_SIZE_OFFSET, 32'h0001ffff, RKPB_RESP_OKAY);
      for (int i = 0; i < 12; i++) begin
         d = (i == 0) ? 32'hffffffff : $urandom;
         s = (i == 0) ? 4'hf : 4'($urandom);
         if (s[1])
            f = d[15:10];
         wr(RKPB_KPB_OFFSET, d, s, RKPB_RESP_OKAY);
         rd(RKPB_KPB_OFFSET, {16'h0, f, 10'h0}, RKPB_RESP_OKAY);
         rd(RKPB_STAT_OFFSET, {30'h0, f != 6'h0, 1'b0}, RKPB_RESP_OKAY);
         chk(34'(kernel_program_ram_base_o), {18'h0, f, 10'h0});
         chk(34'(kernel_program_active_o), 34'(f != 6'h0));
      end
      wr(RKPB_KPB_OFFSET, 32'h0000fc00, 4'h2, RKPB_RESP_OKAY);
      rd(RKPB_KPB_OFFSET, 32'h0000fc00, RKPB_RESP_OKAY);
      // A size below the base is a software fault that status must show
      wr(RKPB_SIZE_OFFSET, 32'h0, 4'hf, RKPB_RESP_OKAY);
      rd(RKPB_STAT_OFFSET, 32'h3, RKPB_RESP_OKAY);
      wr(12'h00c, 32'h5a5a5a5a, 4'hf, RKPB_RESP_SLVERR);
      rd(12'h00c, 32'h0, RKPB_RESP_SLVERR);
      @(posedge clk_i);
      reset_i <= 1'b1;
      repeat (2) @(posedge clk_i);
      reset_i <= 1'b0;
      rd(RKPB_KPB_OFFSET, 32'h0, RKPB_RESP_OKAY);
      chk(34'(kernel_program_ram_base_o), 34'h0);
      summarize();
   end
endmodule
